// >>> hdl/crc_defs.svh
// Constants of the contactless receiver control block.
// Assumes inclusion by bare name from the top module only.
`ifndef CRC_DEFS_SVH
`define CRC_DEFS_SVH
`define CRC_A_QCTL 8'h00
`define CRC_A_RXC1 8'h04
`define CRC_A_PHASE 8'h08
`define CRC_A_LEVEL 8'h0C
`define CRC_A_WAIT 8'h10
`define CRC_A_SWITCH 8'h14
`define CRC_A_RXSTAT 8'h18
`define CRC_QCTL_OVF 5
`define CRC_QCTL_DIS 6
`define CRC_QCTL_BUSY 7
`define CRC_RXC1_CLKSEL 2
`define CRC_RST_GAIN 2'h0
`define CRC_RST_DEC 2'h1
`define CRC_RST_MOD 2'h2
`define CRC_RST_OUT 3'h0
`define CRC_DB_00 6'h14
`define CRC_DB_01 6'h18
`define CRC_DB_10 6'h1F
`define CRC_DB_11 6'h23
`define CRC_CAL_PERIODS 65
`define CRC_MANUAL_WAIT_NS 4800
`define CRC_RESP_OKAY 2'h0
`define CRC_RESP_SLVERR 2'h2
`endif

// >>> hdl/crc_pkg.sv
// Types of the contactless receiver control block.
// Needs no include file; crc_defs.svh is included by the top module only.
package crc_pkg;
    typedef enum logic [1:0] {
        CRC_CAL_IDLE = 2'h0,
        CRC_CAL_RUN = 2'h1,
        CRC_CAL_LOAD = 2'h3
    } crc_cal_e;
endpackage

// >>> hdl/crc_top.sv
// Receive path control: quadrature calibration, bit evaluation, signal switch.
// Assumes an AXI4-Lite master on clk_sys and analog results on the same clock.
`timescale 1ns/1ps
`include "crc_defs.svh"
module crc_top
    import crc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic transceive_done,
    input wire logic [5:0] phase_meas,
    input wire logic [7:0] corr_i_first,
    input wire logic [7:0] corr_i_second,
    input wire logic [7:0] corr_q_first,
    input wire logic [7:0] corr_q_second,
    input wire logic halves_ready,
    input wire logic tx_active,
    input wire logic bit_tick,
    input wire logic analog_rx_out,
    input wire logic demod_out,
    input wire logic encoder_env,
    input wire logic tx_data,
    input wire logic serial_signal_input_pin,
    output logic cal_active,
    output logic [1:0] amp_gain,
    output logic [5:0] amp_gain_db,
    output logic correlator_clock_select,
    output logic [7:0] receive_phase_offset,
    output logic fifo_valid,
    output logic fifo_bit,
    output logic bit_collision,
    output logic decoder_in,
    output logic modulator_in,
    output logic serial_signal_output_pin,
    output logic aux_test_out
);
    localparam int CAL_LAST = `CRC_CAL_PERIODS - 2;
    crc_cal_e cal_state;
    logic [6:0] cal_cnt;
    logic cal_pending;
    logic calibration_disable;
    logic [4:0] quadrature_delay_value;
    logic phase_overflow_flag;
    logic [3:0] minimum_valid_level;
    logic [3:0] collision_level;
    logic [7:0] receiver_turn_on_delay;
    logic [1:0] decoder_input_select;
    logic [1:0] modulation_input_select;
    logic [2:0] output_pin_select;
    logic [2:0] analog_test_select;
    logic [7:0] wait_cnt;
    logic rx_on;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic wr_ok;
    logic trig_sw;
    logic trig_tx;
    logic [31:0] next_rdata;
    logic rd_ok;
    logic s1;
    logic s2;
    logic s3;
    logic sin;
    logic [7:0] h_first;
    logic [7:0] h_second;
    logic [7:0] stronger;
    logic [7:0] weaker;
    logic [11:0] coll_prod;
    logic bit_valid;
    logic bit_coll;

    assign cal_active = cal_state != CRC_CAL_IDLE;
    assign s_axi_awready = !aw_got;
    assign s_axi_wready = !w_got;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_got && w_got && !s_axi_bvalid;
    assign wr_ok = aw_addr <= `CRC_A_RXSTAT && aw_addr[1:0] == 2'h0;
    // Only a 0 to 1 change by software counts as a trigger.
    assign trig_sw = wr_go && aw_addr == `CRC_A_QCTL && w_strb[0]
        && w_data[`CRC_QCTL_DIS] && !calibration_disable;
    assign trig_tx = transceive_done && !calibration_disable;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_got <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && !aw_got) begin
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_got <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            w_got <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && !w_got) begin
            w_got <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_go) begin
            w_got <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CRC_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `CRC_RESP_OKAY : `CRC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            calibration_disable <= 1'b0;
            amp_gain <= `CRC_RST_GAIN;
            correlator_clock_select <= 1'b0;
            receive_phase_offset <= 8'h00;
            minimum_valid_level <= 4'h0;
            collision_level <= 4'h0;
            receiver_turn_on_delay <= 8'h00;
            decoder_input_select <= `CRC_RST_DEC;
            modulation_input_select <= `CRC_RST_MOD;
            output_pin_select <= `CRC_RST_OUT;
            analog_test_select <= 3'h0;
        end else if (wr_go && w_strb[0]) begin
            case (aw_addr)
                `CRC_A_QCTL: calibration_disable <= w_data[`CRC_QCTL_DIS];
                `CRC_A_RXC1: begin
                    amp_gain <= w_data[1:0];
                    correlator_clock_select <= w_data[`CRC_RXC1_CLKSEL];
                end
                `CRC_A_PHASE: receive_phase_offset <= w_data[7:0];
                `CRC_A_LEVEL: begin
                    collision_level <= w_data[3:0];
                    minimum_valid_level <= w_data[7:4];
                end
                `CRC_A_WAIT: receiver_turn_on_delay <= w_data[7:0];
                `CRC_A_SWITCH: begin
                    decoder_input_select <= w_data[1:0];
                    modulation_input_select <= w_data[3:2];
                    output_pin_select <= w_data[6:4];
                end
                default: begin
                end
            endcase
            if (aw_addr == `CRC_A_SWITCH && w_strb[1]) begin
                analog_test_select <= w_data[10:8];
            end
        end else if (wr_go && w_strb[1] && aw_addr == `CRC_A_SWITCH) begin
            analog_test_select <= w_data[10:8];
        end
    end

    // Only the reset request is held until the engine is idle, so the power-up run cannot be lost; triggers during a run are dropped.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cal_pending <= 1'b1;
        end else if (cal_state == CRC_CAL_IDLE) begin
            cal_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cal_state <= CRC_CAL_IDLE;
            cal_cnt <= 7'h00;
        end else begin
            case (cal_state)
                CRC_CAL_IDLE: begin
                    cal_cnt <= 7'h00;
                    if (cal_pending || trig_tx || trig_sw) begin
                        cal_state <= CRC_CAL_RUN;
                    end
                end
                CRC_CAL_RUN: begin
                    cal_cnt <= cal_cnt + 7'h01;
                    if (cal_cnt == CAL_LAST[6:0]) begin
                        cal_state <= CRC_CAL_LOAD;
                    end
                end
                CRC_CAL_LOAD: cal_state <= CRC_CAL_IDLE;
                default: cal_state <= CRC_CAL_IDLE;
            endcase
        end
    end

    // Software writes are ignored mid-run so the result lands intact.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            quadrature_delay_value <= 5'h00;
            phase_overflow_flag <= 1'b0;
        end else if (cal_state == CRC_CAL_LOAD) begin
            quadrature_delay_value <= phase_meas[4:0];
            phase_overflow_flag <= phase_meas[5];
        end else if (wr_go && w_strb[0] && aw_addr == `CRC_A_QCTL && !cal_active) begin
            quadrature_delay_value <= w_data[4:0];
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `CRC_A_QCTL: next_rdata[7:0] = {cal_active, calibration_disable,
                phase_overflow_flag, quadrature_delay_value};
            `CRC_A_RXC1: next_rdata[2:0] = {correlator_clock_select, amp_gain};
            `CRC_A_PHASE: next_rdata[7:0] = receive_phase_offset;
            `CRC_A_LEVEL: next_rdata[7:0] = {minimum_valid_level, collision_level};
            `CRC_A_WAIT: next_rdata[7:0] = receiver_turn_on_delay;
            `CRC_A_SWITCH: next_rdata[10:0] = {analog_test_select, 1'b0,
                output_pin_select, modulation_input_select, decoder_input_select};
            `CRC_A_RXSTAT: next_rdata[2:0] = {bit_collision, fifo_bit, rx_on};
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CRC_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_ok ? `CRC_RESP_OKAY : `CRC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always_comb begin
        case (amp_gain)
            2'h0: amp_gain_db = `CRC_DB_00;
            2'h1: amp_gain_db = `CRC_DB_01;
            2'h2: amp_gain_db = `CRC_DB_10;
            default: amp_gain_db = `CRC_DB_11;
        endcase
    end

    // The receiver stays deaf while sending and for the programmed bit count after.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_on <= 1'b0;
            wait_cnt <= 8'h00;
        end else if (tx_active) begin
            rx_on <= 1'b0;
            wait_cnt <= receiver_turn_on_delay;
        end else if (!rx_on) begin
            if (wait_cnt == 8'h00) begin
                rx_on <= 1'b1;
            end else if (bit_tick) begin
                wait_cnt <= wait_cnt - 8'h01;
            end
        end
    end

    // The chosen clock's channel supplies both half-bit strengths.
    assign h_first = correlator_clock_select ? corr_i_first : corr_q_first;
    assign h_second = correlator_clock_select ? corr_i_second : corr_q_second;
    assign stronger = h_first >= h_second ? h_first : h_second;
    assign weaker = h_first >= h_second ? h_second : h_first;
    assign coll_prod = stronger * collision_level;
    assign bit_valid = stronger >= {minimum_valid_level, 4'h0};
    assign bit_coll = {weaker, 4'h0} > coll_prod;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fifo_valid <= 1'b0;
            fifo_bit <= 1'b0;
            bit_collision <= 1'b0;
        end else begin
            fifo_valid <= halves_ready && rx_on && bit_valid && !bit_coll;
            bit_collision <= halves_ready && rx_on && bit_valid && bit_coll;
            if (halves_ready && rx_on) begin
                fifo_bit <= h_first > h_second;
            end
        end
    end

    // Pin input is only meaningful at 106 kBd, far slower than this filter.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            sin <= 1'b0;
        end else begin
            s1 <= serial_signal_input_pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                sin <= s3;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            decoder_in <= 1'b0;
            modulator_in <= 1'b0;
            serial_signal_output_pin <= 1'b0;
            aux_test_out <= 1'b0;
        end else begin
            case (decoder_input_select)
                2'h0: decoder_in <= 1'b0;
                2'h1: decoder_in <= analog_rx_out;
                default: decoder_in <= sin;
            endcase
            case (modulation_input_select)
                2'h0: modulator_in <= 1'b0;
                2'h1: modulator_in <= 1'b1;
                2'h2: modulator_in <= encoder_env;
                default: modulator_in <= sin;
            endcase
            case (output_pin_select)
                3'h1: serial_signal_output_pin <= 1'b1;
                3'h2: serial_signal_output_pin <= encoder_env;
                3'h3: serial_signal_output_pin <= tx_data;
                3'h4: serial_signal_output_pin <= analog_rx_out;
                3'h5: serial_signal_output_pin <= demod_out;
                default: serial_signal_output_pin <= 1'b0;
            endcase
            case (analog_test_select)
                3'h0: aux_test_out <= analog_rx_out;
                3'h1: aux_test_out <= demod_out;
                3'h2: aux_test_out <= h_first[7];
                3'h3: aux_test_out <= h_second[7];
                3'h4: aux_test_out <= rx_on;
                3'h5: aux_test_out <= cal_active;
                3'h6: aux_test_out <= phase_overflow_flag;
                default: aux_test_out <= sin;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_cal_span;
        ##63 cal_active ##1 cal_active ##1 !cal_active;
    endsequence

    a_cal_length: assert property ($rose(cal_active) |-> s_cal_span)
        else $error("calibration run length wrong");
    a_reset_cal: assert property ($past(!rst_n) |-> ##1 cal_active)
        else $error("no calibration after reset");
    a_tx_cal: assert property (trig_tx && !cal_active |=> cal_active)
        else $error("transceive end did not calibrate");
    a_dis_block: assert property (calibration_disable && !cal_active
        && !cal_pending |=> !cal_active)
        else $error("calibration ran while disabled");
    a_sw_trigger: assert property (trig_sw && !cal_active |=> cal_active)
        else $error("disable rise did not calibrate");
    a_delay_load: assert property (cal_state == CRC_CAL_LOAD
        |=> quadrature_delay_value == $past(phase_meas[4:0]))
        else $error("delay not loaded at run end");
    a_ovf_flag: assert property (cal_state == CRC_CAL_LOAD
        |=> phase_overflow_flag == $past(phase_meas[5]))
        else $error("overflow flag wrong");
    a_run_hold: assert property (cal_state == CRC_CAL_RUN
        |=> $stable(quadrature_delay_value))
        else $error("delay changed during run");
    a_rx_off: assert property (tx_active |=> !rx_on ##1 !fifo_valid)
        else $error("receiver on during transmit");
    a_fifo_min: assert property (fifo_valid |-> $past(rx_on)
        && $past(stronger) >= {$past(minimum_valid_level), 4'h0})
        else $error("weak bit delivered");
endmodule

// >>> tb/crc_card_model.sv
// Card side model: supplies per-bit correlator strengths as a responding card would.
// Assumes the bench requests one bit at a time on send, well apart.
`timescale 1ns/1ps
module crc_card_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic send,
    input wire logic [7:0] first_level,
    input wire logic [7:0] second_level,
    output logic [7:0] corr_i_first,
    output logic [7:0] corr_i_second,
    output logic [7:0] corr_q_first,
    output logic [7:0] corr_q_second,
    output logic halves_ready
);
    logic [7:0] noise;
    // Outside a bit the lines churn, so stale strengths can never pass as fresh ones.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            noise <= 8'h00;
            halves_ready <= 1'h0;
        end else begin
            noise <= noise + 8'h5b;
            halves_ready <= send;
        end
    end
    // The in-phase channel sees half the amplitude, so the clock choice shows in results.
    always_ff @(posedge clk_sys) begin
        corr_i_first <= send ? {1'h0, first_level[7:1]} : noise;
        corr_i_second <= send ? {1'h0, second_level[7:1]} : ~noise;
        corr_q_first <= send ? first_level : ~noise;
        corr_q_second <= send ? second_level : noise;
    end
endmodule

// >>> tb/test_contactless_receiver_control.sv
// Self-checking bench of the receive path control block.
// Assumes the card model and an AXI4-Lite master driven from here.
`timescale 1ns/1ps
module test_contactless_receiver_control;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, amp_gain;
    logic [31:0] s_axi_rdata;
    logic transceive_done = 1'h0, tx_active = 1'h0, bit_tick = 1'h0, send = 1'h0;
    logic analog_rx_out = 1'h0, demod_out = 1'h0, encoder_env = 1'h0, tx_data = 1'h0;
    logic serial_signal_input_pin = 1'h0;
    logic [5:0] phase_meas = 6'h2a;
    logic [7:0] first_level = 8'h00, second_level = 8'h00;
    logic [7:0] corr_i_first, corr_i_second, corr_q_first, corr_q_second;
    logic [7:0] receive_phase_offset;
    logic halves_ready, cal_active, correlator_clock_select, fifo_valid, fifo_bit;
    logic bit_collision, decoder_in, modulator_in, serial_signal_output_pin, aux_test_out;
    logic [5:0] amp_gain_db;
    logic [31:0] rd;
    logic [1:0] rs;
    int miscompares = 0;
    int num_checks = 0;
    int cal_cycles = 0;

    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (cal_active === 1'h1) cal_cycles <= cal_cycles + 1;

    crc_top i_crc_top (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .transceive_done,
        .phase_meas, .corr_i_first, .corr_i_second, .corr_q_first, .corr_q_second,
        .halves_ready, .tx_active, .bit_tick, .analog_rx_out, .demod_out, .encoder_env,
        .tx_data, .serial_signal_input_pin, .cal_active, .amp_gain, .amp_gain_db,
        .correlator_clock_select, .receive_phase_offset, .fifo_valid, .fifo_bit,
        .bit_collision, .decoder_in, .modulator_in, .serial_signal_output_pin, .aux_test_out);
    crc_card_model i_crc_card_model (.clk_sys, .rst_n, .send, .first_level, .second_level,
        .corr_i_first, .corr_i_second, .corr_q_first, .corr_q_second, .halves_ready);

    task automatic tick;
        @(posedge clk_sys);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        if (miscompares == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'h0;
        tick;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!done) begin
            tick;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) begin
                done = 1'h1;
                rs = s_axi_bresp;
                s_axi_bready <= 1'h0;
            end
        end
    endtask

    task automatic axi_read(input logic [7:0] a);
        logic done;
        done = 1'h0;
        tick;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (!done) begin
            tick;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) begin
                done = 1'h1;
                rd = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'h0;
            end
        end
    endtask

    task automatic pulse_tc;
        tick;
        transceive_done <= 1'h1;
        tick;
        transceive_done <= 1'h0;
    endtask

    task automatic test_reset_cal;
        repeat (100) tick;
        check(cal_cycles, 65);
        axi_read(8'h00);
        check(rd, 32'h0000_002a);
    endtask

    task automatic test_transceive_cal;
        int c0;
        axi_write(8'h00, 32'h0000_0005);
        axi_read(8'h00);
        check(rd, 32'h0000_0025);
        phase_meas <= 6'h13;
        c0 = cal_cycles;
        pulse_tc;
        repeat (20) tick;
        pulse_tc;
        repeat (80) tick;
        check(cal_cycles - c0, 65);
        axi_read(8'h00);
        check(rd, 32'h0000_0013);
    endtask

    task automatic test_disable;
        int c0;
        c0 = cal_cycles;
        phase_meas <= 6'h07;
        axi_write(8'h00, 32'h0000_0040);
        repeat (80) tick;
        check(cal_cycles - c0, 65);
        pulse_tc;
        // Software waits well over 4.8 us before a manual delay, as required of it.
        repeat (130) tick;
        axi_write(8'h00, 32'h0000_004b);
        axi_read(8'h00);
        check(rd, 32'h0000_004b);
        check(cal_cycles - c0, 65);
    endtask

    task automatic test_gain;
        logic [5:0] db [4];
        db = '{6'h14, 6'h18, 6'h1f, 6'h23};
        for (int g = 0; g < 4; g++) begin
            axi_write(8'h04, g | ((g & 1) << 2));
            tick;
            check(amp_gain, g);
            check(amp_gain_db, db[g]);
            check(correlator_clock_select, g & 1);
        end
        axi_write(8'h04, 32'h0000_0000);
        axi_write(8'h08, 32'h0000_005a);
        tick;
        check(receive_phase_offset, 8'h5a);
    endtask

    task automatic send_bit(input logic [7:0] f, input logic [7:0] s, input logic v,
            input logic b, input logic c);
        tick;
        send <= 1'h1;
        first_level <= f;
        second_level <= s;
        tick;
        send <= 1'h0;
        tick;
        tick;
        check(fifo_valid, v);
        if (v) check(fifo_bit, b);
        check(bit_collision, c);
    endtask

    task automatic bit_pulse;
        tick;
        bit_tick <= 1'h1;
        tick;
        bit_tick <= 1'h0;
    endtask

    task automatic test_receive;
        axi_write(8'h0c, 32'h0000_0048);
        axi_write(8'h10, 32'h0000_0003);
        tx_active <= 1'h1;
        repeat (3) tick;
        tx_active <= 1'h0;
        send_bit(8'h80, 8'h10, 1'h0, 1'h0, 1'h0);
        bit_pulse;
        bit_pulse;
        repeat (3) tick;
        axi_read(8'h18);
        check(rd[0], 1'h0);
        bit_pulse;
        repeat (3) tick;
        axi_read(8'h18);
        check(rd[0], 1'h1);
        send_bit(8'h80, 8'h10, 1'h1, 1'h1, 1'h0);
        send_bit(8'h10, 8'h90, 1'h1, 1'h0, 1'h0);
        send_bit(8'h80, 8'h70, 1'h0, 1'h0, 1'h1);
        send_bit(8'h40, 8'h00, 1'h1, 1'h1, 1'h0);
        send_bit(8'h3f, 8'h00, 1'h0, 1'h0, 1'h0);
        axi_write(8'h04, 32'h0000_0004);
        send_bit(8'h60, 8'h00, 1'h0, 1'h0, 1'h0);
        axi_write(8'h04, 32'h0000_0000);
        send_bit(8'h60, 8'h00, 1'h1, 1'h1, 1'h0);
    endtask

    task automatic test_switch;
        int m;
        int t;
        logic e;
        for (int p = 0; p < 2; p++) begin
            encoder_env <= p[0];
            analog_rx_out <= p[0];
            tx_data <= !p[0];
            demod_out <= !p[0];
            serial_signal_input_pin <= !p[0];
            // Test selects 2 and 3 show churning strengths, so 6 and 7 stand in.
            for (int i = 0; i < 8; i++) begin
                m = i & 3;
                t = (i == 2 || i == 3) ? i + 4 : i;
                axi_write(8'h14, m | (m << 2) | (i << 4) | (t << 8));
                repeat (8) tick;
                e = i < 2 ? i[0] : (i > 5 ? 1'h0 : p[0] ^ i[0]);
                check(serial_signal_output_pin, e);
                e = m < 2 ? m[0] : p[0] ^ m[0];
                check(modulator_in, e);
                e = m == 0 ? 1'h0 : (m == 1 ? p[0] : !p[0]);
                check(decoder_in, e);
                e = i == 4 ? 1'h1 : (i == 0 ? p[0] : i[0] && i != 5 && !p[0]);
                check(aux_test_out, e);
            end
        end
    endtask

    task automatic test_unmapped;
        axi_read(8'h1c);
        check(rs, 2'h2);
        check(rd, 32'h0000_0000);
        axi_write(8'h1e, 32'h0000_00ff);
        check(rs, 2'h2);
    endtask

    initial begin
        repeat (12) tick;
        rst_n <= 1'h1;
        test_reset_cal;
        test_transceive_cal;
        test_disable;
        test_gain;
        test_receive;
        test_switch;
        test_unmapped;
        conclude;
    end

    // The tests need about eight hundred cycles; this bound leaves ample margin.
    initial begin
        repeat (20000) tick;
        miscompares++;
        conclude;
    end
endmodule
